// >>> vls_pkg.sv
// Package with constants, types and register map of the vector loop sequencer
package vls_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int VLS_CW    = 16;
	localparam int VLS_NVEC  = 3;
	localparam int VLS_ROMW  = 9;
	localparam int VLS_OPW   = 32;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] VLS_OFF_CTRL   = 8'h00;
	localparam logic [7:0] VLS_OFF_SELF   = 8'h04;
	localparam logic [7:0] VLS_OFF_INNER  = 8'h08;
	localparam logic [7:0] VLS_OFF_OUTER  = 8'h0C;
	localparam logic [7:0] VLS_OFF_STATUS = 8'h10;
	localparam logic [7:0] VLS_OFF_HOLD   = 8'h14;
	localparam logic [7:0] VLS_OFF_CNT0   = 8'h18;
	localparam logic [7:0] VLS_CNT_STRIDE = 8'h08;
	localparam logic [7:0] VLS_CNT_OUTER  = 8'h04;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int VLS_CTRL_START  = 0;
	localparam int VLS_CTRL_NEG    = 4;
	localparam int VLS_STAT_BUSY   = 0;
	localparam int VLS_STAT_DONE   = 1;
	localparam int VLS_STAT_VDONE  = 4;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] VLS_CNT_RST = 16'h0000;
	localparam logic [2:0]  VLS_NEG_RST = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		VLS_STEP_NONE  = 4'b0001,
		VLS_STEP_SELF  = 4'b0010,
		VLS_STEP_INNER = 4'b0100,
		VLS_STEP_OUTER = 4'b1000
	} vls_step_e;

	typedef enum logic [4:0] {
		VLS_V_IDLE  = 5'b00001,
		VLS_V_SELF  = 5'b00010,
		VLS_V_INNER = 5'b00100,
		VLS_V_OUTER = 5'b01000,
		VLS_V_DONE  = 5'b10000
	} vls_vstate_e;

	typedef enum logic [8:0] {
		VLS_I_IDLE  = 9'b000000001,
		VLS_I_ROUTE = 9'b000000010,
		VLS_I_START = 9'b000000100,
		VLS_I_FETCH = 9'b000001000,
		VLS_I_ALIGN = 9'b000010000,
		VLS_I_RUN   = 9'b000100000,
		VLS_I_STORE = 9'b001000000,
		VLS_I_NOP   = 9'b010000000,
		VLS_I_CLEAR = 9'b100000000
	} vls_istate_e;

	typedef struct packed {
		logic [VLS_ROMW-1:0] rom_addr;
		logic [VLS_OPW-1:0]  operand;
	} vls_xfer_s;

endpackage

// >>> vls_vector_loop_sequencer.sv
// Vector loop sequencer: loop counters, vector controllers, init control, level 5/6 transfer
//
// Overview of operation
// - Load inner hold at vector start, reuse
// - Load self hold at vector start, reuse
// - Each vector has own counters and controller
// - Self counter loads, decrements per address
// - Zero length or unit vector: no addresses
// - Self counter at one reloads if loops remain
// - Inner count up to one: single self loop
// - Inner counter at one reloads from hold
// - Outer counter loads straight from staging
// - Outer decrements per inner sequence, final pass
// - Outer count load starts a new vector
// - Self count above one enables increment
// - Self at one drops increment, checks inner
// - Inner step adds displacement, reloads self
// - Both at one: stop adder, check outer
// - Outer step adds displacement, restores counters
// - Finished vector stops generation, reports done
// - Init routes parameters, starts, fetches, aligns
// - Clean-up: store, ROM no-op, clear arithmetic
// - Level 6 moves data without loss, reports presence
// - Level 5 takes level 4 data when enabled
// - Self step is one, sign from stride
//
// The implementer's own choices: the address map and register access over APB.
module vls_vector_loop_sequencer
	import vls_pkg::*;
(
	input  logic                         pclk,
	input  logic                         presetn,
	input  logic                         psel,
	input  logic                         penable,
	input  logic                         pwrite,
	input  logic [7:0]                   paddr,
	input  logic [31:0]                  pwdata,
	input  logic [3:0]                   pstrb,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  logic [VLS_NVEC-1:0]          gen_ack,
	output logic [VLS_NVEC-1:0][3:0]     step_sel,
	output logic [VLS_NVEC-1:0]          addr_gen_en,
	output logic [VLS_NVEC-1:0]          self_step_neg,
	output logic [VLS_NVEC-1:0]          vec_done,
	output logic                         first_fetch_req,
	input  logic                         fetch_ack,
	output logic                         align_pulse,
	output logic                         store_req,
	input  logic                         store_ack,
	output logic                         rom_nop,
	output logic                         au_clear,
	output logic                         busy,
	input  logic                         l4_valid,
	input  vls_xfer_s                    l4_xfer,
	output logic                         l4_ready,
	input  logic                         sel_next_en,
	input  logic                         path_clear,
	output vls_xfer_s                    au_xfer,
	output logic                         au_take,
	output logic                         l6_present
);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// APB register access
	// ----------------------------------------------------------------
	logic [VLS_CW-1:0]   stage_self;
	logic [VLS_CW-1:0]   stage_inner;
	logic [VLS_CW-1:0]   stage_outer;
	logic [VLS_CW-1:0]   self_hold;
	logic [VLS_CW-1:0]   inner_hold;
	logic                done_flag;
	vls_istate_e         ist;
	logic [VLS_NVEC-1:0][31:0] cnt_rd;
	logic [VLS_NVEC-1:0] cnt_hit;
	logic [31:0]         cnt_or;
	logic                any_cnt;

	wire        setup   = psel & ~penable;
	wire        wr_acc  = psel & penable & pwrite;
	wire [31:0] wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire        hit_ctl = paddr == VLS_OFF_CTRL;
	wire        hit_slf = paddr == VLS_OFF_SELF;
	wire        hit_inr = paddr == VLS_OFF_INNER;
	wire        hit_otr = paddr == VLS_OFF_OUTER;
	wire        hit_st  = paddr == VLS_OFF_STATUS;
	wire        hit_hld = paddr == VLS_OFF_HOLD;
	wire        hit     = hit_ctl | hit_slf | hit_inr | hit_otr | hit_st | hit_hld | any_cnt;
	wire        i_idle  = ist == VLS_I_IDLE;
	wire        start_w = wr_acc & hit_ctl & pstrb[0] & pwdata[VLS_CTRL_START] & i_idle;
	wire        done_clr = wr_acc & hit_st & pstrb[0] & pwdata[VLS_STAT_DONE];
	wire [31:0] ctl_rd  = {25'h0, self_step_neg, 4'h0};
	wire [31:0] st_rd   = {25'h0, vec_done, 2'h0, done_flag, busy};
	wire [31:0] rd_data = hit_ctl ? ctl_rd :
		hit_slf ? {16'h0, stage_self} :
		hit_inr ? {16'h0, stage_inner} :
		hit_otr ? {16'h0, stage_outer} :
		hit_st  ? st_rd :
		hit_hld ? {inner_hold, self_hold} :
		cnt_or;
	wire [31:0] w_self  = ({16'h0, stage_self} & ~wmask) | (pwdata & wmask);
	wire [31:0] w_inner = ({16'h0, stage_inner} & ~wmask) | (pwdata & wmask);
	wire [31:0] w_outer = ({16'h0, stage_outer} & ~wmask) | (pwdata & wmask);
	wire [31:0] w_ctl   = ({25'h0, self_step_neg, 4'h0} & ~wmask) | (pwdata & wmask);

	always_comb begin
		cnt_or  = 32'h0000_0000;
		any_cnt = 1'b0;
		for (int i = 0; i < VLS_NVEC; i++) begin
			cnt_or  = cnt_or | cnt_rd[i];
			any_cnt = any_cnt | cnt_hit[i];
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata        <= 32'h0000_0000;
			stage_self    <= VLS_CNT_RST;
			stage_inner   <= VLS_CNT_RST;
			stage_outer   <= VLS_CNT_RST;
			self_step_neg <= VLS_NEG_RST;
		end else begin
			if (setup && !pwrite)
				prdata <= rd_data;
			if (wr_acc && hit_slf)
				stage_self <= w_self[15:0];
			if (wr_acc && hit_inr)
				stage_inner <= w_inner[15:0];
			if (wr_acc && hit_otr)
				stage_outer <= w_outer[15:0];
			if (wr_acc && hit_ctl)
				self_step_neg <= w_ctl[VLS_CTRL_NEG +: VLS_NVEC];
		end
	end

	// ----------------------------------------------------------------
	// Vector initialization and clean-up control
	// ----------------------------------------------------------------
	vls_istate_e next_ist;
	wire         vec_start = ist == VLS_I_START;
	wire         all_done  = &vec_done;

	always_comb begin
		next_ist = ist;
		case (ist)
			VLS_I_IDLE:  if (start_w) next_ist = VLS_I_ROUTE;
			VLS_I_ROUTE: next_ist = VLS_I_START;
			VLS_I_START: next_ist = VLS_I_FETCH;
			VLS_I_FETCH: if (fetch_ack) next_ist = VLS_I_ALIGN;
			VLS_I_ALIGN: next_ist = VLS_I_RUN;
			VLS_I_RUN:   if (all_done) next_ist = VLS_I_STORE;
			VLS_I_STORE: if (store_ack) next_ist = VLS_I_NOP;
			VLS_I_NOP:   next_ist = VLS_I_CLEAR;
			VLS_I_CLEAR: next_ist = VLS_I_IDLE;
			default:     next_ist = VLS_I_IDLE;
		endcase
	end

	// Parameters route to holds first; self and inner counters load from holds next cycle
	assign first_fetch_req = ist == VLS_I_FETCH;
	assign align_pulse     = ist == VLS_I_ALIGN;
	assign store_req       = ist == VLS_I_STORE;
	assign rom_nop         = ist == VLS_I_NOP;
	assign au_clear        = ist == VLS_I_CLEAR;
	assign busy            = !i_idle;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist        <= VLS_I_IDLE;
			self_hold  <= VLS_CNT_RST;
			inner_hold <= VLS_CNT_RST;
			done_flag  <= 1'b0;
		end else begin
			ist <= next_ist;
			if (ist == VLS_I_ROUTE) begin
				inner_hold <= stage_inner;
				self_hold  <= stage_self;
			end
			if (au_clear)
				done_flag <= 1'b1;
			else if (done_clr)
				done_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Loop counters and vector controller, one set per vector
	// ----------------------------------------------------------------
	wire vec_nop = (self_hold == 16'h0000) ||
		(self_hold <= 16'h0001 && inner_hold <= 16'h0001 && stage_outer <= 16'h0001);

	for (genvar gv = 0; gv < VLS_NVEC; gv++) begin : g_vec
		logic [VLS_CW-1:0] self_loop_counter;
		logic [VLS_CW-1:0] inner_loop_counter;
		logic [VLS_CW-1:0] outer_loop_counter;
		vls_vstate_e       vst;

		wire flp_term = self_loop_counter <= 16'h0001;
		wire fni_term = inner_loop_counter <= 16'h0001;
		wire fno_term = outer_loop_counter <= 16'h0001;
		wire ack      = gen_ack[gv];
		wire [7:0] base = VLS_OFF_CNT0 + 8'(gv) * VLS_CNT_STRIDE;

		assign cnt_hit[gv] = (paddr == base) || (paddr == base + VLS_CNT_OUTER);
		assign cnt_rd[gv]  = paddr == base ? {inner_loop_counter, self_loop_counter} :
			paddr == base + VLS_CNT_OUTER ? {16'h0, outer_loop_counter} : 32'h0000_0000;
		assign step_sel[gv] = (vst == VLS_V_SELF && !flp_term) ? VLS_STEP_SELF :
			vst == VLS_V_INNER ? VLS_STEP_INNER :
			vst == VLS_V_OUTER ? VLS_STEP_OUTER : VLS_STEP_NONE;
		assign addr_gen_en[gv] = step_sel[gv] != VLS_STEP_NONE;
		assign vec_done[gv]    = vst == VLS_V_DONE;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				self_loop_counter <= VLS_CNT_RST;
				inner_loop_counter <= VLS_CNT_RST;
				outer_loop_counter <= VLS_CNT_RST;
				vst <= VLS_V_IDLE;
			end else if (vec_start) begin
				self_loop_counter <= self_hold;
				inner_loop_counter <= inner_hold;
				outer_loop_counter <= stage_outer;
				vst <= vec_nop ? VLS_V_DONE : VLS_V_SELF;
			end else begin
				case (vst)
					VLS_V_SELF: begin
						if (flp_term)
							vst <= !fni_term ? VLS_V_INNER :
								!fno_term ? VLS_V_OUTER : VLS_V_DONE;
						else if (ack)
							self_loop_counter <= self_loop_counter - 16'h0001;
					end
					VLS_V_INNER: begin
						if (ack) begin
							inner_loop_counter <= inner_loop_counter - 16'h0001;
							self_loop_counter <= self_hold;
							vst <= VLS_V_SELF;
						end
					end
					VLS_V_OUTER: begin
						if (ack) begin
							outer_loop_counter <= outer_loop_counter - 16'h0001;
							inner_loop_counter <= inner_hold;
							self_loop_counter <= self_hold;
							vst <= VLS_V_SELF;
						end
					end
					VLS_V_DONE: if (au_clear) vst <= VLS_V_IDLE;
					default: vst <= VLS_V_IDLE;
				endcase
			end
		end

		property p_self_dec;
			vst == VLS_V_SELF && !flp_term && ack && !vec_start |=> self_loop_counter == $past(self_loop_counter) - 16'h0001;
		endproperty
		a_self_dec: assert property (p_self_dec) else $error("self count did not step");

		property p_nop;
			vec_start && vec_nop |=> vst == VLS_V_DONE && !addr_gen_en[gv];
		endproperty
		a_nop: assert property (p_nop) else $error("empty vector generated");

		property p_inner;
			vst == VLS_V_INNER && ack |=> vst == VLS_V_SELF && self_loop_counter == self_hold &&
				inner_loop_counter == $past(inner_loop_counter) - 16'h0001;
		endproperty
		a_inner: assert property (p_inner) else $error("inner step wrong");

		property p_outer;
			vst == VLS_V_OUTER && ack |=> outer_loop_counter == $past(outer_loop_counter) - 16'h0001 && inner_loop_counter == inner_hold
				&& self_loop_counter == self_hold;
		endproperty
		a_outer: assert property (p_outer) else $error("outer step wrong");

		// Increment drops at count one and the controller leaves the self state in the next cycle
		property p_term;
			vst == VLS_V_SELF && flp_term && !vec_start |-> !addr_gen_en[gv] ##1
				vst != VLS_V_SELF;
		endproperty
		a_term: assert property (p_term) else $error("increment kept at count one");

		property p_finish;
			vst == VLS_V_SELF && flp_term && fni_term && fno_term && !vec_start
				|=> vec_done[gv] && !addr_gen_en[gv];
		endproperty
		a_finish: assert property (p_finish) else $error("vector not finished");
	end

	// ----------------------------------------------------------------
	// Level 5 and level 6 transfer controllers
	// ----------------------------------------------------------------
	vls_xfer_s l5_q;
	logic      l5_full;
	logic      l6_full;

	wire l6_move = l6_full & path_clear;
	wire l6_free = ~l6_full | l6_move;
	wire l5_move = l5_full & sel_next_en & l6_free;
	wire l4_take = l4_valid & l4_ready;

	assign l4_ready   = ~l5_full | l5_move;
	assign au_take    = l6_move;
	assign l6_present = l6_full;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l5_q    <= '0;
			l5_full <= 1'b0;
			au_xfer <= '0;
			l6_full <= 1'b0;
		end else begin
			if (l4_take)
				l5_q <= l4_xfer;
			l5_full <= l4_take | (l5_full & ~l5_move);
			if (l5_move)
				au_xfer <= l5_q;
			l6_full <= l5_move | (l6_full & ~l6_move);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_hold;
		ist == VLS_I_ROUTE |=> inner_hold == $past(stage_inner) && self_hold == $past(stage_self);
	endproperty
	a_hold: assert property (p_hold) else $error("holds not loaded");

	property p_cleanup;
		store_req && store_ack |=> rom_nop ##1 au_clear ##1 !busy && done_flag;
	endproperty
	a_cleanup: assert property (p_cleanup) else $error("clean-up out of order");

	property p_l6;
		l6_full && !path_clear |=> l6_full && au_xfer == $past(au_xfer);
	endproperty
	a_l6: assert property (p_l6) else $error("level 6 data lost");

	property p_l5;
		l5_full && !sel_next_en |-> !l4_ready ##1 l5_full && l5_q == $past(l5_q);
	endproperty
	a_l5: assert property (p_l5) else $error("level 5 advanced while gated");

	c_inner:   cover property (g_vec[0].vst == VLS_V_INNER && gen_ack[0]);
	c_outer:   cover property (g_vec[0].vst == VLS_V_OUTER && gen_ack[0]);
	c_cleanup: cover property (au_clear);
	c_l6:      cover property (au_take && l4_take);

endmodule

// >>> vls_far_model.sv
// Far-side model: address generators, operand fetch and result store acknowledges
module vls_far_model
	import vls_pkg::*;
(
	input  logic                pclk,
	input  logic                presetn,
	input  logic                slow,
	input  logic [VLS_NVEC-1:0] addr_gen_en,
	input  logic                first_fetch_req,
	input  logic                store_req,
	output logic [VLS_NVEC-1:0] gen_ack,
	output logic                fetch_ack,
	output logic                store_ack
);
	timeunit 1ns;
	timeprecision 100ps;

	logic pace;

	// ----------------------------------------------------------------
	// Pacing: prompt answers every cycle, slow ones every other cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pace      <= 1'b0;
			fetch_ack <= 1'b0;
			store_ack <= 1'b0;
		end else begin
			pace      <= slow ? ~pace : 1'b1;
			fetch_ack <= first_fetch_req & ~fetch_ack & pace;
			store_ack <= store_req & ~store_ack & pace;
		end
	end

	// One address per enabled cycle of the pace
	assign gen_ack = addr_gen_en & {VLS_NVEC{pace}};
endmodule

// >>> test_vector_loop_sequencer.sv
// Self-checking bench for the vector loop sequencer
module test_vector_loop_sequencer
	import vls_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic                     pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic                     slow = 0, l4_valid = 0, sel_next_en = 0, path_clear = 0;
	logic [7:0]               paddr = 0;
	logic [31:0]              pwdata = 0;
	logic [3:0]               pstrb = 4'hf;
	vls_xfer_s                l4_xfer = '0;
	logic [31:0]              prdata;
	logic                     pready, pslverr, first_fetch_req, fetch_ack, align_pulse;
	logic                     store_req, store_ack, rom_nop, au_clear, busy;
	logic                     l4_ready, au_take, l6_present;
	logic [VLS_NVEC-1:0][3:0] step_sel;
	logic [VLS_NVEC-1:0]      gen_ack, addr_gen_en, self_step_neg, vec_done;
	vls_xfer_s                au_xfer;
	int                       err_count = 0, compares = 0, n_self, n_inner, n_outer;
	logic [4:0]               seen;

	vls_vector_loop_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .gen_ack(gen_ack),
		.step_sel(step_sel), .addr_gen_en(addr_gen_en), .self_step_neg(self_step_neg),
		.vec_done(vec_done), .first_fetch_req(first_fetch_req), .fetch_ack(fetch_ack),
		.align_pulse(align_pulse), .store_req(store_req), .store_ack(store_ack),
		.rom_nop(rom_nop), .au_clear(au_clear), .busy(busy), .l4_valid(l4_valid),
		.l4_xfer(l4_xfer), .l4_ready(l4_ready), .sel_next_en(sel_next_en),
		.path_clear(path_clear), .au_xfer(au_xfer), .au_take(au_take),
		.l6_present(l6_present));

	vls_far_model far_u (.pclk(pclk), .presetn(presetn), .slow(slow),
		.addr_gen_en(addr_gen_en), .first_fetch_req(first_fetch_req),
		.store_req(store_req), .gen_ack(gen_ack), .fetch_ack(fetch_ack),
		.store_ack(store_ack));

	always #4 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Monitor: addresses per step kind and clean-up activity
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		for (int v = 0; v < VLS_NVEC; v++) begin
			if (gen_ack[v] === 1'b1) begin
				n_self += int'(step_sel[v] === VLS_STEP_SELF);
				n_inner += int'(step_sel[v] === VLS_STEP_INNER);
				n_outer += int'(step_sel[v] === VLS_STEP_OUTER);
			end
		end
		seen = seen | {first_fetch_req, align_pulse, store_req, rom_nop, au_clear};
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		apb(0, VLS_OFF_STATUS, 0, q, e);
		check(q, 0, "status after reset");
		apb(0, VLS_OFF_HOLD, 0, q, e);
		check(q, 0, "holds after reset");
		apb(0, VLS_OFF_CNT0, 0, q, e);
		check(q, 0, "counters after reset");
		apb(0, 8'h40, 0, q, e);
		check(e, 1, "unmapped read error");
	endtask

	task automatic t_vec(input logic [15:0] s, i, o, input logic [2:0] neg);
		logic [31:0] q;
		logic        e;
		int          ie, oe, es, ei, eo, n;
		ie = (i > 1) ? i : 1;
		oe = (o > 1) ? o : 1;
		es = (s > 1) ? ie * oe * (s - 1) : 0;
		ei = oe * (ie - 1);
		eo = oe - 1;
		if (s == 0 || (s <= 1 && i <= 1 && o <= 1)) begin
			ei = 0;
			eo = 0;
		end
		apb(1, VLS_OFF_SELF, {16'h0000, s}, q, e);
		apb(1, VLS_OFF_INNER, {16'h0000, i}, q, e);
		apb(1, VLS_OFF_OUTER, {16'h0000, o}, q, e);
		n_self = 0;
		n_inner = 0;
		n_outer = 0;
		seen = 0;
		apb(1, VLS_OFF_CTRL, {25'h000_0000, neg, 4'h1}, q, e);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
			if (store_req === 1'b1)
				check(vec_done, 3'b111, "all vectors done at store");
		end while (busy !== 1'b0 && n < 5000);
		check(n < 5000, 1, "vector finished in time");
		check(n_self, es * 3, "self steps");
		check(n_inner, ei * 3, "inner steps");
		check(n_outer, eo * 3, "outer steps");
		check(self_step_neg, neg, "step sign");
		check(seen, 5'h1f, "init and clean-up");
		apb(0, VLS_OFF_HOLD, 0, q, e);
		check(q, {i, s}, "hold registers");
		apb(0, VLS_OFF_STATUS, 0, q, e);
		check(q[1:0], 2'b10, "done and idle");
		apb(1, VLS_OFF_STATUS, 32'h0000_0002, q, e);
		apb(0, VLS_OFF_STATUS, 0, q, e);
		check(q, 0, "done flag cleared");
	endtask

	task automatic t_pipe();
		int k, got, n;
		fork
			begin
				for (k = 0; k < 4; k++) begin
					l4_valid <= 1'b1;
					l4_xfer <= {9'(k + 3), 32'hA5A5_0000 + 32'(k)};
					do @(posedge pclk); while (l4_ready !== 1'b1);
				end
				l4_valid <= 1'b0;
				l4_xfer <= ~l4_xfer;
			end
			begin
				got = 0;
				for (n = 0; n < 300 && got < 4; n++) begin
					@(posedge pclk);
					if (sel_next_en !== 1'b1)
						check(l6_present, 0, "level 6 filled without gate");
					if (au_take === 1'b1) begin
						check(au_xfer, {9'(got + 3), 32'hA5A5_0000 + 32'(got)}, "xfer");
						check(path_clear, 1, "take without clear path");
						got++;
					end
					sel_next_en <= (n > 6);
					path_clear <= n[0];
				end
				check(got, 4, "transfer count");
			end
		join
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge pclk);
		check(addr_gen_en, 0, "generation idle in reset");
		check(busy, 0, "busy in reset");
		presetn <= 1'b1;
		t_reset();
		t_vec(3, 2, 2, 3'b101);
		slow <= 1'b1;
		t_vec(4, 0, 3, 3'b010);
		slow <= 1'b0;
		t_vec(0, 5, 5, 3'b000);
		t_vec(1, 1, 1, 3'b000);
		t_vec(2, 1, 0, 3'b111);
		t_vec(1, 3, 1, 3'b000);
		t_pipe();
		close_out();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		close_out();
	end
endmodule
